// ==== logic/adc_setup_pkg.sv ====
// Purpose: shared constants for the converter configuration register and word timer
// Assumes: 200 MHz system clock, register select code of the serial port
// Notes:   field positions run from the mode bits down to the filter sync bit
package adc_setup_pkg;

   // register select code and reset value
   localparam logic [1:0]  SETUP_SELECT    = 2'h1;
   localparam logic [7:0]  SETUP_RESET     = 8'h28;

   // field positions
   localparam int          MODE_HI_BIT     = 7;
   localparam int          MODE_LO_BIT     = 6;
   localparam int          CLK_RANGE_BIT   = 5;
   localparam int          RATE_HI_BIT     = 4;
   localparam int          RATE_LO_BIT     = 3;
   localparam int          POLARITY_BIT    = 2;
   localparam int          BUFFER_BIT      = 1;
   localparam int          SYNC_BIT        = 0;

   // operating modes
   localparam logic [1:0]  MODE_NORMAL     = 2'h0;
   localparam logic [1:0]  MODE_SELF_CAL   = 2'h1;

   // settling in output-word periods
   localparam logic [2:0]  SETTLE_STEP     = 3'h4;
   localparam logic [2:0]  SETTLE_SYNC     = 3'h3;

   // corner frequency in thousandths of the notch frequency
   localparam logic [15:0] CORNER_PER_MILLE = 16'h0106;

   // timing
   localparam int unsigned CLOCK_HZ        = 200_000_000;

   // kind of the last event seen by the word timer
   localparam logic [1:0]  KIND_RUN        = 2'h0;
   localparam logic [1:0]  KIND_SYNC       = 2'h1;
   localparam logic [1:0]  KIND_STEP       = 2'h2;

   typedef enum logic [2:0] {
      ST_HOLD   = 3'b001,
      ST_SETTLE = 3'b010,
      ST_RUN    = 3'b100
   } timer_state_e;

endpackage : adc_setup_pkg

// ==== logic/adc_setup_register.sv ====
// Purpose: converter configuration register with word pacing and self-calibration
// Assumes: serial framing logic on the same clock supplies select, strobes and data
// Notes:   word periods at 200 MHz exceed 4096 cycles; shorten via CLK_HZ
//          mode codes 10 and 11 are stored and run as normal conversion
`timescale 1ns/10ps
module adc_setup_register
   import adc_setup_pkg::*;
#(
   parameter int unsigned CLK_HZ   = CLOCK_HZ,
   parameter int unsigned NOTCH_S0 = 20,
   parameter int unsigned NOTCH_S1 = 25,
   parameter int unsigned NOTCH_S2 = 100,
   parameter int unsigned NOTCH_S3 = 200,
   parameter int unsigned NOTCH_F0 = 50,
   parameter int unsigned NOTCH_F1 = 60,
   parameter int unsigned NOTCH_F2 = 250,
   parameter int unsigned NOTCH_F3 = 500
)(
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic [1:0]  register_select_i,
   input  wire logic        write_i,
   input  wire logic [7:0]  write_data_i,
   input  wire logic        data_read_i,
   output      logic [7:0]  read_data_o,
   output      logic [1:0]  operating_mode_o,
   output      logic        clock_range_o,
   output      logic        unipolar_o,
   output      logic        buffer_en_o,
   output      logic        filter_sync_hold_o,
   output      logic        conversion_ready_flag_b_o,
   output      logic        word_strobe_o,
   output      logic [15:0] notch_hz_o,
   output      logic [31:0] corner_millihz_o
);

   typedef struct packed {
      logic [7:0]  cfg;
      logic        ready_b;
      logic        cal;
      logic [15:0] notch;
      logic [31:0] corner;
   } reg_s;

   reg_s        s_q;
   reg_s        s_d;
   logic        word;
   logic        setup_wr;
   logic [31:0] period;
   logic [2:0]  rate_sel;

   // notch frequency for clock range and rate bits
   function automatic logic [15:0] notch_of(input logic [2:0] sel);
      case (sel)
         3'h0:    notch_of = 16'(NOTCH_S0);
         3'h1:    notch_of = 16'(NOTCH_S1);
         3'h2:    notch_of = 16'(NOTCH_S2);
         3'h3:    notch_of = 16'(NOTCH_S3);
         3'h4:    notch_of = 16'(NOTCH_F0);
         3'h5:    notch_of = 16'(NOTCH_F1);
         3'h6:    notch_of = 16'(NOTCH_F2);
         default: notch_of = 16'(NOTCH_F3);
      endcase
   endfunction : notch_of

   // word period in clock cycles, folded to constants per selection
   function automatic logic [31:0] period_of(input logic [2:0] sel);
      case (sel)
         3'h0:    period_of = 32'(CLK_HZ / NOTCH_S0);
         3'h1:    period_of = 32'(CLK_HZ / NOTCH_S1);
         3'h2:    period_of = 32'(CLK_HZ / NOTCH_S2);
         3'h3:    period_of = 32'(CLK_HZ / NOTCH_S3);
         3'h4:    period_of = 32'(CLK_HZ / NOTCH_F0);
         3'h5:    period_of = 32'(CLK_HZ / NOTCH_F1);
         3'h6:    period_of = 32'(CLK_HZ / NOTCH_F2);
         default: period_of = 32'(CLK_HZ / NOTCH_F3);
      endcase
   endfunction : period_of

   // clock range and rate bits as one table index
   function automatic logic [2:0] rate_sel_of(input logic [7:0] cfg);
      rate_sel_of = {cfg[CLK_RANGE_BIT], cfg[RATE_HI_BIT:RATE_LO_BIT]};
   endfunction : rate_sel_of

   // mode field of a byte asks for self-calibration
   function automatic logic is_self_cal(input logic [7:0] cfg);
      is_self_cal = (cfg[MODE_HI_BIT:MODE_LO_BIT] == MODE_SELF_CAL);
   endfunction : is_self_cal

   ////////////////////////////////////////////////////////////////////////////////
   assign rate_sel = rate_sel_of(s_q.cfg);
   assign period   = period_of(rate_sel);
   assign setup_wr = write_i && (register_select_i == SETUP_SELECT);

   // each setup write restarts the timer unless the stored hold bit is set, so period and restart move together
   word_timer u_timer (
      .clock_i   (clock_i),
      .rst_b_i   (rst_b_i),
      .period_i  (period),
      .hold_i    (s_q.cfg[SYNC_BIT]),
      .restart_i (setup_wr),
      .word_o    (word)
   );

   // ready flag: a read raises it, a new word lowers it, a cal start raises it again;
   // the word is applied after the read so a word on the read cycle is not lost
   always_comb begin
      s_d = s_q;
      if (data_read_i) begin
         s_d.ready_b = 1'b1;
      end
      if (word) begin
         s_d.ready_b = 1'b0;
         if (s_q.cal) begin
            s_d.cal                         = 1'b0;
            s_d.cfg[MODE_HI_BIT:MODE_LO_BIT] = MODE_NORMAL;
         end
      end
      if (setup_wr) begin
         s_d.cfg = write_data_i;
         s_d.cal = is_self_cal(write_data_i);
         if (is_self_cal(write_data_i)) begin
            s_d.ready_b = 1'b1;
         end
      end
      s_d.notch  = notch_of(rate_sel_of(s_d.cfg));
      s_d.corner = 32'(s_d.notch) * 32'(CORNER_PER_MILLE);
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '{cfg: SETUP_RESET, ready_b: 1'b1, cal: 1'b0,
                  notch: 16'(NOTCH_F1),
                  corner: 32'(NOTCH_F1) * 32'(CORNER_PER_MILLE)};
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign read_data_o               = s_q.cfg;
   assign operating_mode_o          = s_q.cfg[MODE_HI_BIT:MODE_LO_BIT];
   assign clock_range_o             = s_q.cfg[CLK_RANGE_BIT];
   assign unipolar_o                = s_q.cfg[POLARITY_BIT];
   assign buffer_en_o               = s_q.cfg[BUFFER_BIT];
   assign filter_sync_hold_o        = s_q.cfg[SYNC_BIT];
   assign conversion_ready_flag_b_o = s_q.ready_b;
   assign word_strobe_o             = word;
   assign notch_hz_o                = s_q.notch;
   assign corner_millihz_o          = s_q.corner;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   sequence cal_start_s;
      setup_wr && is_self_cal(write_data_i);
   endsequence
   sequence read_ack_s;
      data_read_i && !word;
   endsequence
   sequence cal_end_s;
      s_q.cal && word && !setup_wr;
   endsequence

   a_reset_value: assert property (@(posedge clock_i) $rose(rst_b_i) |->
      s_q.cfg == SETUP_RESET) else $error("reset value not loaded");
   a_write_stores: assert property (setup_wr |=> s_q.cfg == $past(write_data_i))
      else $error("write not stored");
   a_other_ignored: assert property (!setup_wr && !(s_q.cal && word) |=> $stable(s_q.cfg))
      else $error("register changed without a write");
   a_cal_raises: assert property (cal_start_s |=> s_q.ready_b && s_q.cal)
      else $error("calibration start did not raise ready flag");
   a_cal_reverts: assert property (cal_end_s |=>
      operating_mode_o == MODE_NORMAL && !s_q.ready_b && !s_q.cal) else $error("cal not reverted");
   a_sync_no_word: assert property (s_q.cfg[SYNC_BIT] |-> !word)
      else $error("word during filter sync hold");
   a_sync_keeps_low: assert property (s_q.cfg[SYNC_BIT] && !s_q.ready_b && !data_read_i
      && !setup_wr |=> !s_q.ready_b) else $error("sync hold cleared ready flag");
   a_corner_ratio: assert property (s_q.corner == 32'(s_q.notch) * 32'd262)
      else $error("corner not 0.262 of notch");
   a_word_ready: assert property (word && !(setup_wr && is_self_cal(write_data_i))
      |=> !s_q.ready_b) else $error("new word did not lower ready flag");

   // register contents
   a_select_refused: assert property (write_i && register_select_i != SETUP_SELECT
      && !(s_q.cal && word) |=> $stable(s_q.cfg)) else $error("other select changed register");
   a_notch_tracks: assert property (setup_wr |=>
      notch_hz_o == notch_of(rate_sel_of($past(write_data_i)))) else $error("notch not updated");
   a_reset_flags: assert property (@(posedge clock_i) $rose(rst_b_i) |->
      s_q.ready_b && !s_q.cal && notch_hz_o == 16'(NOTCH_F1)) else $error("reset flags wrong");

   // ready flag, word strobe and calibration
   a_read_raises: assert property (read_ack_s |=> s_q.ready_b)
      else $error("host read did not raise ready flag");
   a_word_pulse: assert property (word |=> !word)
      else $error("word strobe longer than one cycle");
   a_write_restarts: assert property (setup_wr |=> !word)
      else $error("word right after a restart");
   a_cal_held: assert property (s_q.cal && !word && !setup_wr |=>
      s_q.cal && operating_mode_o == MODE_SELF_CAL) else $error("cal ended without a word");
   a_cal_only_code: assert property (setup_wr && !is_self_cal(write_data_i)
      |=> !s_q.cal) else $error("calibration started by another mode code");

endmodule : adc_setup_register

// ==== logic/word_timer.sv ====
// Purpose: paces output words from the programmed notch period
// Assumes: period_i changes only together with restart_i
// Notes:   hold_i keeps the filter in reset; gap and kind feed the checks only
`timescale 1ns/10ps
module word_timer
   import adc_setup_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   input  wire logic [31:0] period_i,
   input  wire logic        hold_i,
   input  wire logic        restart_i,
   output      logic        word_o
);

   typedef struct packed {
      timer_state_e state;
      logic [31:0]  cnt;
      logic [2:0]   left;
      logic [31:0]  gap;
      logic [1:0]   kind;
   } timer_s;

   timer_s s_q;
   timer_s s_d;
   logic   word;
   logic   release_evt;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d         = s_q;
      word        = 1'b0;
      release_evt = (s_q.state == ST_HOLD) && !hold_i;
      if (hold_i) begin
         s_d.state = ST_HOLD;
         s_d.cnt   = '0;
      end else if (restart_i) begin
         s_d.state = ST_SETTLE;
         s_d.cnt   = '0;
         s_d.left  = SETTLE_STEP;
         s_d.kind  = KIND_STEP;
      end else begin
         case (s_q.state)
            ST_HOLD: begin
               s_d.state = ST_SETTLE;
               s_d.cnt   = '0;
               s_d.left  = SETTLE_SYNC;
               s_d.kind  = KIND_SYNC;
            end
            ST_SETTLE: begin
               if (s_q.cnt >= period_i - 32'h1) begin
                  s_d.cnt = '0;
                  if (s_q.left <= 3'h1) begin
                     word      = 1'b1;
                     s_d.state = ST_RUN;
                  end else begin
                     s_d.left = s_q.left - 3'h1;
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 32'h1;
               end
            end
            ST_RUN: begin
               if (s_q.cnt >= period_i - 32'h1) begin
                  s_d.cnt = '0;
                  word    = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt + 32'h1;
               end
            end
            default: begin
               s_d.state = ST_HOLD;
               s_d.cnt   = '0;
            end
         endcase
      end
      if (restart_i || release_evt || word) begin
         s_d.gap = '0;
      end else begin
         s_d.gap = s_q.gap + 32'h1;
      end
      if (word) begin
         s_d.kind = KIND_RUN;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '{state: ST_SETTLE, cnt: '0, left: SETTLE_STEP, gap: '0, kind: KIND_STEP};
      end else begin
         s_q <= s_d;
      end
   end

   assign word_o = word;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   a_run_spacing: assert property (word && s_q.kind == KIND_RUN |->
      s_q.gap + 32'h1 == period_i) else $error("word spacing differs from period");
   a_sync_settle: assert property (word && s_q.kind == KIND_SYNC |->
      s_q.gap + 32'h1 == 32'(period_i * 32'd3)) else $error("sync settle not three periods");
   a_step_settle: assert property (word && s_q.kind == KIND_STEP |->
      s_q.gap + 32'h1 <= 32'(period_i * 32'd4)) else $error("step settle above four periods");

endmodule : word_timer

// ==== testbench/adc_setup_register_tb.sv ====
// Purpose: self-checking bench for the configuration register
// Assumes: CLK_HZ of 8000 shortens word periods to between 16 and 400 cycles
// Notes:   table rows first, then timing, hold, calibration and reset
`timescale 1ns/10ps
module adc_setup_register_tb;
   import adc_setup_pkg::*;
   logic        clock_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic [1:0]  sel;
   logic        wr;
   logic        rd;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic [1:0]  mode;
   logic        clk_rng;
   logic        unip;
   logic        buf_en;
   logic        hold;
   logic        rdy_b;
   logic        word;
   logic [15:0] notch;
   logic [31:0] corner;
   int          n_errors  = 0;
   int          cmp_count = 0;
   int          cyc       = 0;
   int          n;
   logic [23:0] rows [9] = '{24'hc0_0014, 24'h00_0014, 24'h0a_0019, 24'h14_0064, 24'h1e_00c8,
                             24'h20_0032, 24'h2a_003c, 24'h34_00fa, 24'h3e_01f4};
   always #2.5 clock_i = ~clock_i;
   host_model i_host (.clock_i(clock_i), .register_select_o(sel), .write_o(wr),
                      .write_data_o(wdata), .data_read_o(rd));
   adc_setup_register #(.CLK_HZ(8000)) i_dut (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .register_select_i(sel), .write_i(wr),
      .write_data_i(wdata), .data_read_i(rd), .read_data_o(rdata),
      .operating_mode_o(mode), .clock_range_o(clk_rng), .unipolar_o(unip),
      .buffer_en_o(buf_en), .filter_sync_hold_o(hold),
      .conversion_ready_flag_b_o(rdy_b), .word_strobe_o(word), .notch_hz_o(notch),
      .corner_millihz_o(corner));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_word(output int k);
      k = 0;
      do begin
         @(posedge clock_i) #1;
         k++;
      end while (word !== 1'b1 && k < 2000);
   endtask : wait_word
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clock_i);
      #1 rst_b_i = 1'b1;
      chk(rdata, 32'h28);
      chk({mode, clk_rng, unip, buf_en, hold, rdy_b}, 32'h11);
      chk(notch, 32'h3c);
      foreach (rows[i]) begin
         i_host.write_reg(SETUP_SELECT, rows[i][23:16]);
         chk(rdata, rows[i][23:16]);
         chk({mode, clk_rng, unip, buf_en, hold}, {rows[i][23:21], rows[i][18:16]});
         chk(notch, rows[i][15:0]);
         chk(corner, 32'(rows[i][15:0]) * 32'h106);
      end
      // other selects leave the register alone
      i_host.write_reg(2'h0, 8'hff);
      i_host.write_reg(2'h3, 8'h81);
      chk(rdata, 32'h3e);
      // 500 Hz notch: period of 16 cycles; n starts one edge after the write edge
      i_host.write_reg(SETUP_SELECT, 8'h38);
      wait_word(n);
      chk(n + 1, 32'h40);
      wait_word(n);
      chk(n, 32'h10);
      @(posedge clock_i) #1;
      chk(rdy_b, 32'h0);
      i_host.write_reg(SETUP_SELECT, 8'h39);
      repeat (60) begin
         @(posedge clock_i) #1;
         if (word !== 1'b0) chk(word, 32'h0);
      end
      chk(rdy_b, 32'h0);
      // count starts at the first edge that sees the hold bit low
      i_host.write_reg(SETUP_SELECT, 8'h38);
      wait_word(n);
      chk(n, 32'h30);
      i_host.ack_read();
      chk(rdy_b, 32'h1);
      // self-calibration at 60 Hz: period of 133 cycles
      i_host.write_reg(SETUP_SELECT, 8'h68);
      chk({mode, rdy_b}, 32'h3);
      wait_word(n);
      chk(n + 1, 32'h214);
      @(posedge clock_i) #1;
      chk({mode, rdy_b}, 32'h0);
      // reset in mid-run
      i_host.write_reg(SETUP_SELECT, 8'h1e);
      rst_b_i = 1'b0;
      #1;
      chk(rdata, 32'h28);
      chk(notch, 32'h3c);
      @(posedge clock_i) #1;
      rst_b_i = 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
      chk(rdata, 32'h28);
      chk({mode, clk_rng, unip, buf_en, hold, rdy_b}, 32'h11);
      stop_test();
   end
endmodule : adc_setup_register_tb

// ==== testbench/host_model.sv ====
// Purpose: host side of the serial port, seen at register level
// Assumes: lines change 1 ns after the rising edge
// Notes:   data lines idle at the inverse of the last byte
`timescale 1ns/10ps
module host_model (
   input  wire logic       clock_i,
   output      logic [1:0] register_select_o,
   output      logic       write_o,
   output      logic [7:0] write_data_o,
   output      logic       data_read_o
);
   initial begin
      register_select_o = 2'h0;
      write_o           = 1'b0;
      write_data_o      = 8'h00;
      data_read_o       = 1'b0;
   end
   // caller keeps the clock range bit matched to its master clock
   task automatic write_reg(input logic [1:0] sel, input logic [7:0] d);
      @(posedge clock_i) #1;
      register_select_o = sel;
      write_data_o      = d;
      write_o           = 1'b1;
      @(posedge clock_i) #1;
      write_o           = 1'b0;
      register_select_o = 2'h0;
      write_data_o      = ~d;
   endtask : write_reg
   task automatic ack_read();
      @(posedge clock_i) #1;
      data_read_o = 1'b1;
      @(posedge clock_i) #1;
      data_read_o = 1'b0;
   endtask : ack_read
endmodule : host_model
